// ### design/fault_irq_enable_status.sv
// How it works
// - enable field reads 0h off, 2h on
// - write 1h disables, 3h enables a field
// - gate register at 0Ch, resets to AAh
// - global enable lives in bits 7-6
// - bus timeout enable bits 5-4, reset 2h
// - bad string enable bits 3-2, reset 2h
// - shared led fault enable bits 1-0
// - bits 15-8 reserved, read zero
// - supply status at 0Eh, resets to zero
// - status plus ack both one clears fault
// - checksum flag bit 15, ack bit 14
// - sync loss flag bit 13, ack 12
// - pump fault flag bit 11, ack 10
// - pump capacitor flag bit 9, ack 8
// - supply flags 7,5,3,1, ack one below
// - led flags register at offset 12h
//
// Chosen here: register access over AXI4-Lite.
module fault_irq_enable_status
  import fault_irq_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire supply_faults_t supply_fault,
  input wire string_faults_t string_fault,
  output logic irq
);

  // next enable bit from a written two-bit code; 0h and 2h leave it alone
  function automatic logic en_next(input logic cur, input logic [1:0] code);
    logic r;
    r = cur;
    if (code == EN_WRITE_ON) begin
      r = 1'b1;
    end else if (code == EN_WRITE_OFF) begin
      r = 1'b0;
    end
    return r;
  endfunction : en_next

  // read code of an enable field
  function automatic logic [1:0] en_code(input logic en);
    return en ? EN_READ_ON : EN_READ_OFF;
  endfunction : en_code

  // flag/ack pair clears only when both bits are written as one
  function automatic logic pair_ack(input logic [15:0] d, input int flag_bit);
    return d[flag_bit] & d[flag_bit - 1];
  endfunction : pair_ack

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // write and read channel holding registers
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // handshakes; address and data taken in either order
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready = ~w_hold_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // write decode; lane 0 holds bits 7:0, lane 1 bits 15:8
  wire [15:0] lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wr_data = wdata_q[15:0] & lane_mask;
  wire wr_gate = do_wr & (awaddr_q == STRING_IRQ_GATE_ADDR) & wstrb_q[0];
  wire wr_supply = do_wr & (awaddr_q == SUPPLY_STATUS_ADDR);
  wire wr_string = do_wr & (awaddr_q == STRING_FLAGS_ADDR);
  wire wr_mask = do_wr & (awaddr_q == SUPPLY_MASK_ADDR);
  wire wr_hit = (awaddr_q == STRING_IRQ_GATE_ADDR) | (awaddr_q == SUPPLY_STATUS_ADDR) |
    (awaddr_q == STRING_FLAGS_ADDR) | (awaddr_q == SUPPLY_MASK_ADDR);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (w_fire) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // enable bits: global, bus timeout, bad string, string faults
  logic en_global_q;
  logic en_bus_q;
  logic en_bad_q;
  logic en_string_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_global_q <= STRING_IRQ_GATE_RESET[GLOBAL_EN_LSB + 1];
      en_bus_q <= STRING_IRQ_GATE_RESET[BUS_TIMEOUT_EN_LSB + 1];
      en_bad_q <= STRING_IRQ_GATE_RESET[BAD_STRING_EN_LSB + 1];
      en_string_q <= STRING_IRQ_GATE_RESET[STRING_EN_LSB + 1];
    end else if (wr_gate) begin
      en_global_q <= en_next(en_global_q, wr_data[GLOBAL_EN_LSB +: 2]);
      en_bus_q <= en_next(en_bus_q, wr_data[BUS_TIMEOUT_EN_LSB +: 2]);
      en_bad_q <= en_next(en_bad_q, wr_data[BAD_STRING_EN_LSB +: 2]);
      en_string_q <= en_next(en_string_q, wr_data[STRING_EN_LSB +: 2]);
    end
  end

  // gate register read word; upper byte reserved and zero
  wire [15:0] gate_word = {8'h00, en_code(en_global_q), en_code(en_bus_q),
    en_code(en_bad_q), en_code(en_string_q)};

  // supply flags, index i sits at status bit 2i+1, ack at 2i
  logic [7:0] supply_flag_q;
  logic [7:0] supply_flag_d;
  logic [7:0] supply_ack;
  logic [15:0] supply_word;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      supply_ack[i] = wr_supply & pair_ack(wr_data, 2 * i + 1);
      // a fault present in the clear cycle survives the clear
      supply_flag_d[i] = supply_fault[i] | (supply_flag_q[i] & ~supply_ack[i]);
      supply_word[2 * i + 1] = supply_flag_q[i];
      supply_word[2 * i] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      supply_flag_q <= 8'h00;
    end else begin
      supply_flag_q <= supply_flag_d;
    end
  end

  // supply mask, held at the status bit positions
  logic [7:0] supply_mask_q;
  logic [15:0] mask_word;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mask_word[2 * i + 1] = supply_mask_q[i];
      mask_word[2 * i] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      supply_mask_q <= SUPPLY_MASK_RESET;
    end else if (wr_mask) begin
      for (int i = 0; i < 8; i++) begin
        if (wstrb_q[i / 4]) begin
          supply_mask_q[i] <= wdata_q[2 * i + 1];
        end
      end
    end
  end

  // string fault sticky flags
  logic bus_flag_q;
  logic bad_flag_q;
  logic string_flag_q;
  wire string_evt = string_fault.led_open | string_fault.led_short | string_fault.led_gnd;
  wire bus_ack = wr_string & pair_ack(wr_data, BUS_TIMEOUT_FLAG_BIT);
  wire bad_ack = wr_string & pair_ack(wr_data, BAD_STRING_FLAG_BIT);
  wire string_ack = wr_string & pair_ack(wr_data, STRING_FLAG_BIT);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_flag_q <= 1'b0;
      bad_flag_q <= 1'b0;
      string_flag_q <= 1'b0;
    end else begin
      bus_flag_q <= string_fault.bus_timeout | (bus_flag_q & ~bus_ack);
      bad_flag_q <= string_fault.bad_string_cfg | (bad_flag_q & ~bad_ack);
      string_flag_q <= string_evt | (string_flag_q & ~string_ack);
    end
  end

  // string flags read word; live fault bits are not latched
  logic [15:0] string_word;
  always_comb begin
    string_word = 16'h0000;
    string_word[BUS_TIMEOUT_FLAG_BIT] = bus_flag_q;
    string_word[BAD_STRING_FLAG_BIT] = bad_flag_q;
    string_word[STRING_FLAG_BIT] = string_flag_q;
    string_word[GND_LIVE_BIT] = string_fault.led_gnd;
    string_word[SHORT_LIVE_BIT] = string_fault.led_short;
    string_word[OPEN_LIVE_BIT] = string_fault.led_open;
    string_word[5:0] = string_fault.chan_fault;
  end

  // read mux; unmapped addresses answer zero with slverr
  wire rd_gate = s_axi_araddr == STRING_IRQ_GATE_ADDR;
  wire rd_supply = s_axi_araddr == SUPPLY_STATUS_ADDR;
  wire rd_string = s_axi_araddr == STRING_FLAGS_ADDR;
  wire rd_mask = s_axi_araddr == SUPPLY_MASK_ADDR;
  wire rd_hit = rd_gate | rd_supply | rd_string | rd_mask;
  wire [15:0] rd_word = ({16{rd_gate}} & gate_word) | ({16{rd_supply}} & supply_word) |
    ({16{rd_string}} & string_word) | ({16{rd_mask}} & mask_word);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // interrupt: any enabled flag, all behind the global enable
  wire irq_src = (|(supply_flag_q & supply_mask_q)) | (bus_flag_q & en_bus_q) |
    (bad_flag_q & en_bad_q) | (string_flag_q & en_string_q);
  logic irq_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= en_global_q & irq_src;
    end
  end
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_q);

  chk_gate_read_codes: assert property (
    gate_word[15:8] == 8'h00 && gate_word[6] == 1'b0 && gate_word[4] == 1'b0 &&
    gate_word[2] == 1'b0 && gate_word[0] == 1'b0)
    else $error("enable field read code out of set");

  chk_gate_reset_value: assert property (
    $rose(rst_n_q) |-> gate_word == STRING_IRQ_GATE_RESET)
    else $error("gate register reset value wrong");

  chk_supply_reset_zero: assert property (
    $rose(rst_n_q) |-> supply_word == SUPPLY_STATUS_RESET)
    else $error("supply status not zero after reset");

  chk_global_disable_code: assert property (
    wr_gate && wr_data[7:6] == EN_WRITE_OFF |=> !en_global_q ##1 !irq)
    else $error("global disable code not honoured");

  chk_bus_enable_code: assert property (
    wr_gate && wr_data[5:4] == EN_WRITE_ON |=> gate_word[5:4] == EN_READ_ON)
    else $error("bus timeout enable code not honoured");

  chk_keep_on_code_two: assert property (
    wr_gate && wr_data[3:2] == EN_READ_ON |=> en_bad_q == $past(en_bad_q))
    else $error("code two changed an enable");

  chk_checksum_clear: assert property (
    wr_supply && wr_data[15] && wr_data[14] && !supply_fault.checksum
    |=> !supply_word[15] ##1
    (!supply_word[15] || supply_fault.checksum || $past(supply_fault.checksum)))
    else $error("checksum flag not cleared");

  chk_half_write_keeps: assert property (
    wr_supply && wr_data[13] && !wr_data[12] && supply_flag_q[6] |=> supply_word[13])
    else $error("half write cleared sync loss flag");

  chk_fault_sticks: assert property (
    supply_fault.pump |=> supply_word[11] ##1 (supply_word[11] || $past(supply_ack[5])))
    else $error("pump fault flag not sticky");

  chk_irq_raise: assert property (
    en_global_q && supply_flag_q[3] && supply_mask_q[3] && !wr_gate && !wr_supply && !wr_mask
    |=> irq)
    else $error("enabled fault did not raise irq");

  chk_led_summary: assert property (
    string_fault.led_short |=> string_word[STRING_FLAG_BIT])
    else $error("led fault summary flag not set");

  chk_write_response: assert property (
    do_wr |=> s_axi_bvalid ##0 (s_axi_bresp == (wr_hit ? RESP_OKAY : RESP_SLVERR)) [*1])
    else $error("write response not one cycle after write");

  cov_enable_written: cover property (wr_gate && wr_data[1:0] == EN_WRITE_OFF);
  cov_fault_cleared: cover property (supply_flag_q[0] ##1 !supply_flag_q[0]);
  cov_irq_rise: cover property ($rose(irq));
  cov_unmapped_read: cover property (ar_fire && !rd_hit);

endmodule : fault_irq_enable_status

// ### design/fault_irq_pkg.sv
package fault_irq_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] STRING_IRQ_GATE_IDX = 8'h0C;
  localparam logic [7:0] SUPPLY_STATUS_IDX = 8'h0E;
  localparam logic [7:0] STRING_FLAGS_IDX = 8'h12;
  localparam logic [7:0] SUPPLY_MASK_IDX = 8'h14;
  localparam logic [31:0] STRING_IRQ_GATE_ADDR = {22'h000000, STRING_IRQ_GATE_IDX, 2'h0};
  localparam logic [31:0] SUPPLY_STATUS_ADDR = {22'h000000, SUPPLY_STATUS_IDX, 2'h0};
  localparam logic [31:0] STRING_FLAGS_ADDR = {22'h000000, STRING_FLAGS_IDX, 2'h0};
  localparam logic [31:0] SUPPLY_MASK_ADDR = {22'h000000, SUPPLY_MASK_IDX, 2'h0};

  // reset values
  localparam logic [15:0] STRING_IRQ_GATE_RESET = 16'h00AA;
  localparam logic [15:0] SUPPLY_STATUS_RESET = 16'h0000;
  localparam logic [7:0] SUPPLY_MASK_RESET = 8'hFF;

  // two-bit enable field positions inside the string fault gate register
  localparam int GLOBAL_EN_LSB = 6;
  localparam int BUS_TIMEOUT_EN_LSB = 4;
  localparam int BAD_STRING_EN_LSB = 2;
  localparam int STRING_EN_LSB = 0;

  // enable field codes
  localparam logic [1:0] EN_READ_OFF = 2'h0;
  localparam logic [1:0] EN_READ_ON = 2'h2;
  localparam logic [1:0] EN_WRITE_OFF = 2'h1;
  localparam logic [1:0] EN_WRITE_ON = 2'h3;

  // string fault flags register: flag/ack pairs and live bits
  localparam int BUS_TIMEOUT_FLAG_BIT = 14;
  localparam int BAD_STRING_FLAG_BIT = 12;
  localparam int STRING_FLAG_BIT = 10;
  localparam int GND_LIVE_BIT = 8;
  localparam int SHORT_LIVE_BIT = 7;
  localparam int OPEN_LIVE_BIT = 6;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // supply fault events, msb pairs with status bit 15
  typedef struct packed {
    logic checksum;
    logic sync_loss;
    logic pump;
    logic pump_capacitor_missing;
    logic input_overcurrent;
    logic core_supply_low;
    logic input_overvoltage;
    logic input_undervoltage;
  } supply_faults_t;

  // led string fault events
  typedef struct packed {
    logic bus_timeout;
    logic bad_string_cfg;
    logic led_open;
    logic led_short;
    logic led_gnd;
    logic [5:0] chan_fault;
  } string_faults_t;

endpackage : fault_irq_pkg

// ### tb/host_bus_model.sv
module host_bus_model
  import fault_irq_pkg::*;
(
  input wire logic clock,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = '0;
  end

  // status and ack of a clear always travel in one data beat
  // readies sampled mid-cycle: they only move on rising edges
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clock);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge clock);
      if (aw_ok) begin
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines do not keep the old value
      end
      if (w_ok) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    bready <= 1'b0;
  endtask : wr

  // read: hold address until taken, rready until data seen
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_ok, ok;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock);
      a_ok = arvalid & arready;
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (a_ok) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    rready <= 1'b0;
  endtask : rd
endmodule : host_bus_model

// ### tb/tb_fault_irq_enable_status.sv
module tb_fault_irq_enable_status
  import fault_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] G = STRING_IRQ_GATE_ADDR;
  localparam logic [31:0] S = SUPPLY_STATUS_ADDR;
  localparam logic [31:0] F = STRING_FLAGS_ADDR;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam logic [1:0] ER = RESP_SLVERR;
  typedef struct packed {
    logic [31:0] a;
    logic [15:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic [1:0] r;
  } row_t;
  // write a word, read it back
  localparam row_t ROWS [10] = '{
    '{G, 16'h0055, 4'hF, 16'h0000, OK},
    '{G, 16'h00FF, 4'hF, 16'h00AA, OK},
    '{G, 16'h0000, 4'hF, 16'h00AA, OK},
    '{G, 16'h001D, 4'hF, 16'h0088, OK},
    '{G, 16'hFF57, 4'hF, 16'h0002, OK},
    '{G, 16'h00AA, 4'hF, 16'h0002, OK},
    '{G, 16'h00FF, 4'h2, 16'h0002, OK},
    '{G, 16'h00FF, 4'hF, 16'h00AA, OK},
    '{S, 16'hFFFF, 4'hF, 16'h0000, OK},
    '{32'h40, 16'h0001, 4'hF, 16'h0000, ER}};
  int sb [5] = '{10, 9, 8, 7, 6};
  int fb [5] = '{14, 12, 10, 10, 10};
  int eb [5] = '{4, 2, 0, 0, 0};
  logic clock, nrst;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [1:0] bresp, rresp, resp;
  supply_faults_t sf;
  string_faults_t stf;
  int n_mismatch, compares;

  fault_irq_enable_status u_dut (
    .clock(clock), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_fault(sf), .string_fault(stf), .irq(irq));

  host_bus_model u_host (
    .clock, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic w(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s = 4'hF);
    u_host.wr(a, {16'h0, d}, s, resp);
  endtask : w

  task automatic r(input logic [31:0] a, input logic [15:0] e, input logic [1:0] er = OK);
    u_host.rd(a, rd_v, resp);
    check(rd_v, {16'h0, e}, "read data");
    check({30'h0, resp}, {30'h0, er}, "read resp");
  endtask : r

  // irq looked at mid-cycle, clear of the edge that launches it
  task automatic ci(input logic e);
    @(negedge clock);
    check({31'h0, irq}, {31'h0, e}, "irq level");
    @(posedge clock);
  endtask : ci

  task automatic complete_run;
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // whole run is under a thousand cycles; this only catches a hang
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    sf = '0;
    stf = '0;
    cyc(12);
    nrst <= 1'b1;
    cyc(3);
    r(G, 16'h00AA);
    r(S, 16'h0000);
    r(F, 16'h0000);
    r(SUPPLY_MASK_ADDR, 16'hAAAA);
    ci(1'b0);
    foreach (ROWS[i]) begin
      w(ROWS[i].a, ROWS[i].d, ROWS[i].s);
      check({30'h0, resp}, {30'h0, ROWS[i].r}, "write resp");
      r(ROWS[i].a, ROWS[i].e, ROWS[i].r);
    end
    // each supply event: sticky flag, half writes ignored, full clear
    for (int i = 0; i < 8; i++) begin
      sf <= supply_faults_t'(8'h01 << i);
      cyc(1);
      sf <= '0;
      cyc(3);
      r(S, 16'h0002 << (2 * i));
      ci(1'b1);
      w(S, 16'h0002 << (2 * i));
      w(S, 16'h0001 << (2 * i));
      r(S, 16'h0002 << (2 * i));
      w(S, 16'h0003 << (2 * i));
      r(S, 16'h0000);
      ci(1'b0);
    end
    // global gate over a pending fault; a held fault survives a clear
    sf <= supply_faults_t'(8'h80);
    w(G, 16'h0040);
    cyc(2);
    ci(1'b0);
    w(G, 16'h00C0);
    cyc(2);
    ci(1'b1);
    w(S, 16'hC000);
    r(S, 16'h8000);
    sf <= '0;
    w(S, 16'hC000);
    r(S, 16'h0000);
    // masked supply flag stays off the irq line until unmasked
    w(SUPPLY_MASK_ADDR, 16'hAAA8);
    r(SUPPLY_MASK_ADDR, 16'hAAA8);
    sf <= supply_faults_t'(8'h01);
    cyc(1);
    sf <= '0;
    cyc(3);
    r(S, 16'h0002);
    ci(1'b0);
    w(SUPPLY_MASK_ADDR, 16'hAAAA);
    cyc(2);
    ci(1'b1);
    w(S, 16'h0003);
    r(S, 16'h0000);
    // string events and their own enables
    for (int k = 0; k < 5; k++) begin
      stf <= string_faults_t'(11'h001 << sb[k]);
      cyc(1);
      stf <= '0;
      cyc(3);
      r(F, 16'h0001 << fb[k]);
      ci(1'b1);
      w(G, 16'h0001 << eb[k]);
      cyc(2);
      ci(1'b0);
      w(G, 16'h0003 << eb[k]);
      w(F, 16'h0003 << (fb[k] - 1));
      r(F, 16'h0000);
    end
    stf <= string_faults_t'(11'h02A);
    cyc(2);
    r(F, 16'h002A);
    stf <= '0;
    // reset in mid-run with state changed and a flag set
    w(G, 16'h0055);
    sf <= supply_faults_t'(8'h01);
    cyc(1);
    sf <= '0;
    cyc(2);
    nrst <= 1'b0;
    cyc(12);
    nrst <= 1'b1;
    cyc(3);
    r(G, 16'h00AA);
    r(S, 16'h0000);
    ci(1'b0);
    complete_run();
  end
endmodule : tb_fault_irq_enable_status
